/* hpf_pkg.sv */
// Constants and carrier types for the host pin function block
package hpf_pkg;
	// ***************************************
	// Register offsets
	// ***************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] AWAKE_OFS = 8'h04;
	localparam logic [7:0] SLEEP_OFS = 8'h08;
	localparam logic [7:0] TMO_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] TXDATA_OFS = 8'h14;
	localparam logic [7:0] RXDATA_OFS = 8'h18;
	// ***************************************
	// Field positions
	// ***************************************
	localparam int CTRL_ROLE_LSB = 0;
	localparam int CTRL_ALT_ACT = 2;
	localparam int CTRL_ALT_DCD = 3;
	localparam int CTRL_FLOW = 4;
	localparam int CTRL_SLEEP = 5;
	localparam int CFG_DIR_LSB = 0;
	localparam int CFG_PU_LSB = 8;
	localparam int CFG_OUT_LSB = 16;
	localparam int CFG_WAKE_LSB = 24;
	localparam int ST_LINK = 0;
	localparam int ST_RX_FULL = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_PIN_LSB = 8;
	localparam int CTS_PIN = 3;
	localparam int RTS_PIN = 4;
	// ***************************************
	// Masks and reset values
	// ***************************************
	localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
	localparam logic [31:0] AWAKE_MASK = 32'h1F1F_1F1F;
	localparam logic [31:0] SLEEP_MASK = 32'h001F_1F1F;
	localparam logic [31:0] TMO_MASK = 32'h0000_FFFF;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] AWAKE_RST = 32'h0000_0000;
	localparam logic [31:0] SLEEP_RST = 32'h0000_0000;
	localparam logic [31:0] TMO_RST = 32'h0000_03E8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ***************************************
	// Timing
	// ***************************************
	localparam int CLK_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int BLINK_NS = 20000000;
	localparam int BIT_NS = 8680;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int BLINK_CYCLES = BLINK_NS / CLK_NS;
	localparam int BIT_CYCLES = BIT_NS / CLK_NS;
	localparam logic [5:0] HOP_LOSS = 6'h32;
	// ***************************************
	// Types
	// ***************************************
	typedef enum logic [1:0] {
		ROLE_BASE = 2'h0,
		ROLE_REMOTE = 2'h1,
		ROLE_ROUTER = 2'h2
	} hpf_role_type;
	typedef struct packed {
		logic rx_valid;
		logic rx_upstream;
		logic tx_pkt;
		logic tx_downstream;
		logic sync_acq;
		logic hop;
		logic beacon;
	} hpf_evt_type;
	typedef struct packed {
		logic [4:0] wake;
		logic [4:0] out;
		logic [4:0] pu;
		logic [4:0] dir;
	} hpf_pin_cfg_type;
endpackage

/* hpf_top.sv */
// Host pin functions: activity, carrier detect, general pins, host serial
//Contract
//- Base: blink on each valid received packet
//- Remote: blink on each transmitted packet
//- Router: blink on upstream rx, downstream tx
//- Alternate: activity pin carries debug serial out
//- Base: carrier on rx, off after timeout
//- Others: carrier on sync, off 50 hops
//- Alternate: carrier pin is debug serial input
//- Input pins: pull-up and wake from sleep
//- Output pins drive configured level from power-on
//- Sleep uses separate direction, pull-up, level
//- Pins 1, 2 match pin 0; pins 3, 4 too when flow control off
//- Clear-to-send low only when input accepted
//- No new output byte while request high
//- Serial out to host, serial in from host
//- Low reset input resets whole block
`timescale 1ns/1ns
`default_nettype none

// ***************************************
// Data FIFO
// ***************************************
module hpf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_chk
		$error("fifo depth must be a power of two");
	end
	assign in_ready = cnt_q != DEPTH[AW:0];
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ***************************************
// Top
// ***************************************
module hpf_top #(
	parameter int FIFO_DEPTH = 32,
	parameter logic [31:0] PIN_INIT = hpf_pkg::AWAKE_RST,
	parameter int MS_CYCLES = hpf_pkg::MS_CYCLES,
	parameter int BLINK_CYCLES = hpf_pkg::BLINK_CYCLES,
	parameter int BIT_CYCLES = hpf_pkg::BIT_CYCLES
)(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire hpf_pkg::hpf_evt_type EVENTS,
	input wire logic DEBUG_TX_SRC,
	output logic DEBUG_RX_DATA,
	output logic TRAFFIC_BLINK_OUT,
	output logic LINK_CARRIER_OUT_N,
	output logic LINK_CARRIER_OE_N,
	input wire logic DEBUG_SERIAL_IN,
	input wire logic [4:0] GENERAL_PIN_IN,
	output logic [4:0] GENERAL_PIN_OUT,
	output logic [4:0] GENERAL_PIN_OE_N,
	output logic [4:0] GENERAL_PIN_PULLUP,
	output logic WAKE_REQ,
	output logic SERIAL_TO_HOST,
	input wire logic SERIAL_FROM_HOST
);
	import hpf_pkg::*;
	if (MS_CYCLES < 1 || BLINK_CYCLES < 1 || BIT_CYCLES < 4)
	begin : g_chk
		$error("timing counts out of range");
	end
	localparam hpf_pin_cfg_type INIT_CFG = hpf_pin_cfg_type'({PIN_INIT[28:24],
		PIN_INIT[20:16], PIN_INIT[12:8], PIN_INIT[4:0]});

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be, input logic [31:0] msk);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic hpf_pin_cfg_type to_cfg(input logic [31:0] w);
		to_cfg = '{wake: w[CFG_WAKE_LSB +: 5], out: w[CFG_OUT_LSB +: 5],
			pu: w[CFG_PU_LSB +: 5], dir: w[CFG_DIR_LSB +: 5]};
	endfunction

	// ***************************************
	// Register bus
	// ***************************************
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_full_q, w_full_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] ctrl_q, awake_q, sleep_q, tmo_q;
	logic rx_full_q, overrun_q, link_q;
	logic [7:0] rx_data_q;
	logic tx_in_ready, tx_out_valid, tx_out_ready;
	logic [7:0] tx_out_data;

	wire aw_hs = S_AXI_AWVALID & awready_q;
	wire w_hs = S_AXI_WVALID & wready_q;
	wire ar_hs = S_AXI_ARVALID & arready_q;
	wire b_hs = bvalid_q & S_AXI_BREADY;
	wire r_hs = rvalid_q & S_AXI_RREADY;
	wire wr_tx = awaddr_q == TXDATA_OFS;
	wire wr_do = aw_full_q & w_full_q & ~bvalid_q & (~wr_tx | tx_in_ready);
	wire wr_map = awaddr_q == CTRL_OFS || awaddr_q == AWAKE_OFS || awaddr_q == SLEEP_OFS
		|| awaddr_q == TMO_OFS || awaddr_q == STATUS_OFS || wr_tx;
	wire aw_full_d = aw_hs | (aw_full_q & ~wr_do);
	wire w_full_d = w_hs | (w_full_q & ~wr_do);
	wire rvalid_d = ar_hs | (rvalid_q & ~r_hs);
	wire wr_ctrl = wr_do & awaddr_q == CTRL_OFS;
	wire wr_awake = wr_do & awaddr_q == AWAKE_OFS;
	wire wr_sleep = wr_do & awaddr_q == SLEEP_OFS;
	wire wr_tmo = wr_do & awaddr_q == TMO_OFS;
	wire ovr_clr = wr_do & awaddr_q == STATUS_OFS & wstrb_q[0] & wdata_q[ST_OVERRUN];
	wire rd_pop = ar_hs & S_AXI_ARADDR == RXDATA_OFS;
	wire [31:0] status_w = {19'h0, GENERAL_PIN_IN, 4'h0, ~tx_out_valid, overrun_q,
		rx_full_q, link_q};
	wire [31:0] rd_word = S_AXI_ARADDR == CTRL_OFS ? ctrl_q :
		S_AXI_ARADDR == AWAKE_OFS ? awake_q :
		S_AXI_ARADDR == SLEEP_OFS ? sleep_q :
		S_AXI_ARADDR == TMO_OFS ? tmo_q :
		S_AXI_ARADDR == STATUS_OFS ? status_w :
		S_AXI_ARADDR == RXDATA_OFS ? {24'h0, rx_data_q} : 32'h0000_0000;
	wire rd_map = S_AXI_ARADDR <= RXDATA_OFS && S_AXI_ARADDR[1:0] == 2'h0;

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q <= ~w_full_d;
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (aw_hs)
				awaddr_q <= S_AXI_AWADDR;
			if (w_hs)
			begin
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
			if (wr_do)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (b_hs)
				bvalid_q <= 1'b0;
			if (ar_hs)
			begin
				rdata_q <= rd_word;
				rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			ctrl_q <= CTRL_RST;
			awake_q <= PIN_INIT & AWAKE_MASK;
			sleep_q <= SLEEP_RST;
			tmo_q <= TMO_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q, CTRL_MASK);
			if (wr_awake)
				awake_q <= merge(awake_q, wdata_q, wstrb_q, AWAKE_MASK);
			if (wr_sleep)
				sleep_q <= merge(sleep_q, wdata_q, wstrb_q, SLEEP_MASK);
			if (wr_tmo)
				tmo_q <= merge(tmo_q, wdata_q, wstrb_q, TMO_MASK);
		end
	end

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY = wready_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// ***************************************
	// Activity blink and carrier detect
	// ***************************************
	logic [31:0] ms_cnt_q, blink_cnt_q;
	logic [15:0] idle_ms_q;
	logic [5:0] miss_q;
	logic blink_pend_q;
	wire [1:0] role = ctrl_q[CTRL_ROLE_LSB +: 2];
	wire alt_act = ctrl_q[CTRL_ALT_ACT];
	wire alt_dcd = ctrl_q[CTRL_ALT_DCD];
	wire flow_en = ctrl_q[CTRL_FLOW];
	wire sleeping = ctrl_q[CTRL_SLEEP];
	wire ms_tick = ms_cnt_q == 32'(MS_CYCLES - 1);
	wire is_base = role == ROLE_BASE;
	wire blink_evt = is_base ? EVENTS.rx_valid :
		role == ROLE_REMOTE ? EVENTS.tx_pkt :
		role == ROLE_ROUTER ? (EVENTS.rx_valid & EVENTS.rx_upstream)
		| (EVENTS.tx_pkt & EVENTS.tx_downstream) : 1'b0;
	wire blink_idle = blink_cnt_q == 32'h0000_0000;
	wire blink_on = blink_cnt_q > 32'(BLINK_CYCLES);
	wire [5:0] miss_inc = miss_q + 6'h01;
	wire [15:0] idle_inc = idle_ms_q + 16'h0001;
	wire peer_seen = EVENTS.sync_acq | EVENTS.beacon;

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			ms_cnt_q <= 32'h0000_0000;
			blink_cnt_q <= 32'h0000_0000;
			blink_pend_q <= 1'b0;
		end
		else
		begin
			ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
			if (blink_idle && (blink_evt || blink_pend_q))
				blink_cnt_q <= 32'(2 * BLINK_CYCLES);
			else if (!blink_idle)
				blink_cnt_q <= blink_cnt_q - 32'h0000_0001;
			if (blink_evt && !blink_idle)
				blink_pend_q <= 1'b1;
			else if (blink_idle)
				blink_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			link_q <= 1'b0;
			idle_ms_q <= 16'h0000;
			miss_q <= 6'h00;
		end
		else if (is_base)
		begin
			miss_q <= 6'h00;
			if (EVENTS.rx_valid)
			begin
				link_q <= 1'b1;
				idle_ms_q <= 16'h0000;
			end
			else if (ms_tick && link_q)
			begin
				idle_ms_q <= idle_inc;
				if (idle_inc >= tmo_q[15:0])
					link_q <= 1'b0;
			end
		end
		else
		begin
			idle_ms_q <= 16'h0000;
			if (EVENTS.sync_acq)
				link_q <= 1'b1;
			if (peer_seen)
				miss_q <= 6'h00;
			else if (EVENTS.hop && link_q)
			begin
				miss_q <= miss_inc;
				if (miss_inc >= HOP_LOSS)
					link_q <= 1'b0;
			end
		end
	end

	// ***************************************
	// Host serial path
	// ***************************************
	logic tx_busy_q, rx_busy_q;
	logic [9:0] tx_shift_q;
	logic [3:0] tx_bit_q, rx_bit_q;
	logic [31:0] tx_baud_q, rx_baud_q;
	logic [7:0] rx_shift_q;
	wire tx_hold = flow_en & GENERAL_PIN_IN[RTS_PIN];
	wire tx_bit_end = tx_baud_q == 32'(BIT_CYCLES - 1);
	wire rx_bit_end = rx_baud_q == 32'(BIT_CYCLES - 1);
	wire rx_done = rx_busy_q & rx_bit_end & rx_bit_q == 4'h9;
	assign tx_out_ready = ~tx_busy_q & ~tx_hold;

	hpf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.in_data(wdata_q[7:0]),
		.in_valid(wr_do & wr_tx),
		.in_ready(tx_in_ready),
		.out_data(tx_out_data),
		.out_valid(tx_out_valid),
		.out_ready(tx_out_ready)
	);

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			tx_busy_q <= 1'b0;
			tx_shift_q <= 10'h3FF;
			tx_bit_q <= 4'h0;
			tx_baud_q <= 32'h0000_0000;
		end
		else if (tx_out_valid && tx_out_ready)
		begin
			tx_busy_q <= 1'b1;
			tx_shift_q <= {1'b1, tx_out_data, 1'b0};
			tx_bit_q <= 4'h0;
			tx_baud_q <= 32'h0000_0000;
		end
		else if (tx_busy_q)
		begin
			tx_baud_q <= tx_bit_end ? 32'h0000_0000 : tx_baud_q + 32'h0000_0001;
			if (tx_bit_end)
			begin
				tx_shift_q <= {1'b1, tx_shift_q[9:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_busy_q <= tx_bit_q != 4'h9;
			end
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			rx_busy_q <= 1'b0;
			rx_bit_q <= 4'h0;
			rx_baud_q <= 32'h0000_0000;
			rx_shift_q <= 8'h00;
			rx_data_q <= 8'h00;
			rx_full_q <= 1'b0;
			overrun_q <= 1'b0;
		end
		else
		begin
			if (!rx_busy_q && !SERIAL_FROM_HOST)
			begin
				rx_busy_q <= 1'b1;
				rx_bit_q <= 4'h0;
				rx_baud_q <= 32'(BIT_CYCLES / 2);
			end
			else if (rx_busy_q)
			begin
				rx_baud_q <= rx_bit_end ? 32'h0000_0000 : rx_baud_q + 32'h0000_0001;
				if (rx_bit_end)
				begin
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q == 4'h0 && SERIAL_FROM_HOST)
						rx_busy_q <= 1'b0;
					else if (rx_bit_q != 4'h9)
						rx_shift_q <= {SERIAL_FROM_HOST, rx_shift_q[7:1]};
					else
						rx_busy_q <= 1'b0;
				end
			end
			if (rx_done)
				rx_data_q <= rx_shift_q;
			if (rx_done)
				rx_full_q <= 1'b1;
			else if (rd_pop)
				rx_full_q <= 1'b0;
			if (rx_done && rx_full_q && !rd_pop)
				overrun_q <= 1'b1;
			else if (ovr_clr)
				overrun_q <= 1'b0;
		end
	end

	// ***************************************
	// Pin drive
	// ***************************************
	wire hpf_pin_cfg_type awake_cfg = to_cfg(awake_q);
	wire hpf_pin_cfg_type act_cfg = sleeping ? to_cfg(sleep_q) : awake_cfg;
	wire [4:0] pin_in_mode = ~act_cfg.dir;
	wire [4:0] pin_out_d = flow_en ? {act_cfg.out[4], rx_full_q, act_cfg.out[2:0]}
		: act_cfg.out;
	wire [4:0] pin_oe_n_d = flow_en ? {1'b1, 1'b0, pin_in_mode[2:0]} : pin_in_mode;
	wire [4:0] pin_pu_d = act_cfg.pu & pin_oe_n_d;
	wire wake_d = sleeping & |(awake_cfg.wake & pin_oe_n_d & ~GENERAL_PIN_IN);

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			GENERAL_PIN_OUT <= INIT_CFG.out;
			GENERAL_PIN_OE_N <= ~INIT_CFG.dir;
			GENERAL_PIN_PULLUP <= INIT_CFG.pu & ~INIT_CFG.dir;
			WAKE_REQ <= 1'b0;
			TRAFFIC_BLINK_OUT <= 1'b0;
			LINK_CARRIER_OUT_N <= 1'b1;
			LINK_CARRIER_OE_N <= 1'b0;
			DEBUG_RX_DATA <= 1'b1;
			SERIAL_TO_HOST <= 1'b1;
		end
		else
		begin
			GENERAL_PIN_OUT <= pin_out_d;
			GENERAL_PIN_OE_N <= pin_oe_n_d;
			GENERAL_PIN_PULLUP <= pin_pu_d;
			WAKE_REQ <= wake_d;
			TRAFFIC_BLINK_OUT <= alt_act ? DEBUG_TX_SRC : blink_on;
			LINK_CARRIER_OUT_N <= ~link_q;
			LINK_CARRIER_OE_N <= alt_dcd;
			DEBUG_RX_DATA <= alt_dcd ? DEBUG_SERIAL_IN : 1'b1;
			SERIAL_TO_HOST <= tx_busy_q ? tx_shift_q[0] : 1'b1;
		end
	end

	// ***************************************
	// Checks
	// ***************************************
	a_base_blink: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		is_base && !alt_act && EVENTS.rx_valid && blink_idle && !wr_ctrl
		|-> ##2 TRAFFIC_BLINK_OUT) else $error("base blink missing");
	a_remote_blink: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		role == ROLE_REMOTE && EVENTS.tx_pkt && blink_idle |=> blink_on [*2])
		else $error("remote blink missing");
	a_router_blink: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		role == ROLE_ROUTER && EVENTS.rx_valid && !EVENTS.rx_upstream && !EVENTS.tx_pkt
		&& blink_idle && !blink_pend_q |=> blink_idle) else $error("router blink wrong");
	a_act_alt_out: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		alt_act |=> TRAFFIC_BLINK_OUT == $past(DEBUG_TX_SRC)) else $error("debug out wrong");
	a_base_carrier: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		is_base && EVENTS.rx_valid |=> link_q ##1 !LINK_CARRIER_OUT_N)
		else $error("base carrier missing");
	a_hop_loss: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!is_base && link_q && miss_q == 6'h31 && EVENTS.hop && !peer_seen && !wr_ctrl
		|=> !link_q) else $error("carrier held past hop limit");
	a_dcd_input: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		alt_dcd && !wr_ctrl |=> LINK_CARRIER_OE_N && $stable(alt_dcd))
		else $error("carrier pin still driven");
	a_cts_level: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		flow_en |=> !GENERAL_PIN_OE_N[CTS_PIN] && GENERAL_PIN_OUT[CTS_PIN] == $past(rx_full_q))
		else $error("clear-to-send wrong");
	a_rts_stall: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		tx_hold && !tx_busy_q |=> !tx_busy_q) else $error("sent while request high");
	a_sleep_dir: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		sleeping && !flow_en |=> GENERAL_PIN_OE_N == ~$past(sleep_q[4:0]))
		else $error("sleep direction wrong");
endmodule
`default_nettype wire

/* hpf_host_model.sv */
// Host side serial model with hardware flow control
`timescale 1ns/1ns
`default_nettype none
module hpf_host_model #(
	parameter int BITC = 8
)(
	input wire logic clk,
	input wire logic to_host,
	input wire logic cts_n,
	input wire logic hold,
	output logic from_host,
	output logic rts_n,
	output logic [7:0] got,
	output int got_cnt
);
	// Permission follows the bench's hold request
	assign rts_n = hold;
	initial
	begin
		from_host = 1'b1;
		got = 8'h00;
		got_cnt = 0;
	end
	// Receiver, mid-bit sampling
	initial
	begin
		forever
		begin
			@(negedge to_host);
			repeat (BITC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BITC) @(posedge clk);
				got[i] = to_host;
			end
			repeat (BITC) @(posedge clk);
			got_cnt++;
		end
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		wait (cts_n === 1'b0);
		@(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			from_host <= f[i];
			repeat (BITC) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

/* host_pin_functions_tb.sv */
// Self-checking bench for the host pin function block
`timescale 1ns/1ns
`default_nettype none
module host_pin_functions_tb;
	import hpf_pkg::*;
	localparam int BL = 4;
	localparam int BT = 8;
	logic clk, rst_n, awv, wv, brdy, arv, rrdy, dbg_tx, dbg_in, hold;
	logic [7:0] aw_addr, ar_addr, rx_byte;
	logic [31:0] w_data, rdat;
	logic [3:0] wstrb;
	logic [1:0] resp;
	logic [4:0] ext_v;
	hpf_evt_type evt;
	wire logic awr, wr_rdy, bv, arr, rv, dbg_rx, traffic, link_n, link_oe_n, wake, to_host;
	wire logic from_host, rts_n, dcd_in;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [4:0] gp_in, gp_out, gp_oe_n, gp_pu;
	int got_cnt;
	int err_total = 0;
	int num_checks = 0;
	// Wire levels seen by the block's inputs
	assign gp_in = (~gp_oe_n & gp_out) | (gp_oe_n & {rts_n, ext_v[3:0]});
	assign dcd_in = link_oe_n ? dbg_in : link_n;
	hpf_top #(.PIN_INIT(32'h0001_0001), .MS_CYCLES(10), .BLINK_CYCLES(BL),
		.BIT_CYCLES(BT)) u_hpf_top (
		.REF_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .EVENTS(evt),
		.DEBUG_TX_SRC(dbg_tx), .DEBUG_RX_DATA(dbg_rx), .TRAFFIC_BLINK_OUT(traffic),
		.LINK_CARRIER_OUT_N(link_n), .LINK_CARRIER_OE_N(link_oe_n), .DEBUG_SERIAL_IN(dcd_in),
		.GENERAL_PIN_IN(gp_in), .GENERAL_PIN_OUT(gp_out), .GENERAL_PIN_OE_N(gp_oe_n),
		.GENERAL_PIN_PULLUP(gp_pu), .WAKE_REQ(wake), .SERIAL_TO_HOST(to_host),
		.SERIAL_FROM_HOST(from_host));
	hpf_host_model #(.BITC(BT)) u_hpf_host_model (.clk(clk), .to_host(to_host),
		.cts_n(gp_out[CTS_PIN]), .hold(hold), .from_host(from_host), .rts_n(rts_n),
		.got(rx_byte), .got_cnt(got_cnt));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		aw_addr <= a;
		w_data <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_rdy) wv <= 1'b0;
		end while (!(bv === 1'b1) && n < 5000);
		chk(bv, 1'b1);
		r = bresp;
		brdy <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		ar_addr <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arv && arr) arv <= 1'b0;
		end while (!(rv === 1'b1) && n < 5000);
		chk(rv, 1'b1);
		d = rdata;
		r = rresp;
		rrdy <= 1'b0;
	endtask
	task automatic pulse(input logic [6:0] e);
		@(posedge clk);
		evt <= hpf_evt_type'(e);
		@(posedge clk);
		evt <= hpf_evt_type'(7'h00);
	endtask
	task automatic t_reset;
		tick(1);
		chk(traffic, 1'b0);
		chk(link_n, 1'b1);
		chk(to_host, 1'b1);
		chk(gp_oe_n, 5'h1E);
		chk(gp_out[0], 1'b1);
		rd(TMO_OFS, rdat, resp);
		chk(rdat, TMO_RST);
		rd(8'h40, rdat, resp);
		chk(resp, RESP_SLVERR);
		wr(8'h40, 32'h0000_0001, resp);
		chk(resp, RESP_SLVERR);
	endtask
	task automatic t_blink;
		logic [6:0] ev [4] = '{7'h40, 7'h60, 7'h10, 7'h18};
		logic [3:0] tbl [3] = '{4'b0011, 4'b1100, 4'b1010};
		for (int r = 0; r < 3; r++)
		begin
			wr(CTRL_OFS, r, resp);
			for (int i = 0; i < 4; i++)
			begin
				pulse(ev[i]);
				tick(1);
				chk(traffic, tbl[r][i]);
				tick(BL - 1);
				chk(traffic, tbl[r][i]);
				tick(1);
				chk(traffic, 1'b0);
				tick(BL + 4);
			end
		end
	endtask
	task automatic t_carrier;
		wr(TMO_OFS, 32'h0000_0002, resp);
		wr(CTRL_OFS, ROLE_BASE, resp);
		tick(60);
		chk(link_n, 1'b1);
		pulse(7'h40);
		tick(2);
		chk(link_n, 1'b0);
		tick(8);
		chk(link_n, 1'b0);
		tick(30);
		chk(link_n, 1'b1);
		wr(CTRL_OFS, ROLE_REMOTE, resp);
		pulse(7'h04);
		tick(2);
		chk(link_n, 1'b0);
		repeat (49) pulse(7'h02);
		tick(3);
		chk(link_n, 1'b0);
		pulse(7'h02);
		tick(2);
		chk(link_n, 1'b1);
	endtask
	task automatic t_alt;
		wr(CTRL_OFS, 32'h0000_000C, resp);
		tick(3);
		chk(link_oe_n, 1'b1);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk);
			dbg_tx <= v[0];
			dbg_in <= v[0];
			tick(4);
			chk(traffic, v[0]);
			chk(dbg_rx, v[0]);
		end
	endtask
	task automatic t_pins;
		wr(AWAKE_OFS, 32'h0505_0A15, resp);
		tick(4);
		chk(gp_oe_n, 5'h0A);
		chk(gp_out & 5'h15, 5'h05);
		chk(gp_pu, 5'h0A);
		wr(SLEEP_OFS, 32'h000A_040A, resp);
		wr(CTRL_OFS, 32'h0000_0020, resp);
		tick(4);
		chk(gp_oe_n, 5'h15);
		chk(gp_out & 5'h0A, 5'h0A);
		chk(gp_pu, 5'h04);
		chk(wake, 1'b0);
		@(posedge clk);
		ext_v <= 5'h1E;
		tick(4);
		chk(wake, 1'b1);
		@(posedge clk);
		ext_v <= 5'h1F;
		wr(CTRL_OFS, 32'h0000_0000, resp);
	endtask
	task automatic t_serial;
		wr(AWAKE_OFS, 32'h0000_0008, resp);
		wr(CTRL_OFS, 32'h0000_0010, resp);
		for (int i = 0; i < 32; i++) wr(TXDATA_OFS, i, resp);
		fork
			wr(TXDATA_OFS, 32'h0000_0020, resp);
			begin
				tick(100);
				chk(bv, 1'b0);
				chk(got_cnt, 0);
				chk(to_host, 1'b1);
				@(posedge clk);
				hold <= 1'b0;
			end
		join
		for (int n = 0; n < 4000 && got_cnt < 33; n++) tick(1);
		chk(got_cnt, 33);
		chk(rx_byte, 8'h20);
		u_hpf_host_model.send(8'h3C);
		tick(20);
		chk(gp_out[CTS_PIN], 1'b1);
		rd(STATUS_OFS, rdat, resp);
		chk(rdat, 32'h0000_0F0A);
		rd(RXDATA_OFS, rdat, resp);
		chk(rdat[7:0], 8'h3C);
		tick(4);
		chk(gp_out[CTS_PIN], 1'b0);
	endtask
	task automatic test_done;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#500000;
		err_total++;
		test_done();
	end
	initial
	begin
		{rst_n, awv, wv, brdy, arv, rrdy, dbg_tx, dbg_in} = 8'h02;
		{aw_addr, ar_addr, w_data} = 48'h0;
		wstrb = 4'hF;
		ext_v = 5'h1F;
		hold = 1'b1;
		evt = hpf_evt_type'(7'h00);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_blink();
		t_carrier();
		t_alt();
		t_pins();
		t_serial();
		test_done();
	end
endmodule
`default_nettype wire
